// *** pbc_pkg.sv ***
// Constants shared by the port B style general-purpose I/O block.
// Assumes an 8-bit register port with 3-bit word addresses.
`default_nettype none
package pbc_pkg;
	// Port width.
	localparam int unsigned PORT_W = 8;
	// Register addresses on the plain register port.
	localparam logic [2:0] ADDR_PIN_VALUE = 3'h0;
	localparam logic [2:0] ADDR_OUTPUT_LATCH = 3'h1;
	localparam logic [2:0] ADDR_DIRECTION = 3'h2;
	localparam logic [2:0] ADDR_INT_MAIN = 3'h3;
	localparam logic [2:0] ADDR_INT_SECOND = 3'h4;
	localparam logic [2:0] ADDR_INT_THIRD = 3'h5;
	localparam logic [2:0] ADDR_ANALOG_CFG = 3'h6;
	// Field positions.
	localparam int BIT_CHANGE_FLAG = 0;
	localparam int BIT_CHANGE_ENABLE = 3;
	localparam int BIT_PULLUP_DISABLE_N = 7;
	localparam int BIT_CHANGE_PRIORITY = 0;
	localparam int BIT_CAN_TX = 2;
	localparam int BIT_CAN_RX = 3;
	localparam int BIT_LV_PROGRAM = 5;
	localparam int CHANGE_LO = 4;
	localparam int ANALOG_HI = 4;
	// Values after reset.
	localparam logic [7:0] RST_DIRECTION = 8'hFF;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [3:0] PCFG_ALL_ANALOG = 4'h0;
	localparam logic [3:0] PCFG_ALL_DIGITAL = 4'hF;
	// Low pins are digital once the analog field reaches this code.
	localparam logic [3:0] PCFG_DIGITAL_MIN = 4'h5;
	// Cycles of pin synchronisation.
	localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// *** pbc_change_if.sv ***
// Interface between the port top and its change detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pbc_change_if;
	logic [7:0] pin_read;
	logic [7:0] direction;
	logic refresh;
	logic mismatch;
	modport port (output pin_read, output direction, output refresh,
		input mismatch);
	modport detect (input pin_read, input direction, input refresh,
		output mismatch);
endinterface
`default_nettype wire

// *** pbc_sync.sv ***
// Two flip-flop synchroniser for a bundle of static or slow levels.
// Assumes each bit is independent; no word coherence is promised.
`timescale 1ns/1ps
`default_nettype none
module pbc_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;

	// The first stage feeds only the second to contain metastability.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stage1 <= '0;
			o_sync <= '0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule
`default_nettype wire

// *** pbc_change_detect.sv ***
// Change comparison on the upper four port pins.
// Assumes pin_read is already synchronised and analog-masked.
`timescale 1ns/1ps
`default_nettype none
module pbc_change_detect (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset,
	// Port side.
	pbc_change_if.detect chg
);
	logic [3:0] snapshot;
	logic [3:0] live;
	logic [3:0] inputs_only;

	assign live = chg.pin_read[7:pbc_pkg::CHANGE_LO];
	assign inputs_only = chg.direction[7:pbc_pkg::CHANGE_LO];

	// Snapshot follows every qualifying port access.
	always_ff @(posedge i_clk) begin
		if (i_reset || chg.refresh) begin
			snapshot <= live;
		end
	end

	// The access cycle itself already counts as matched, so a read never
	// leaves a one-cycle stale mismatch behind.
	assign chg.mismatch = !chg.refresh &&
		(|((live ^ snapshot) & inputs_only));

	property p_refresh_loads;
		@(posedge i_clk) disable iff (i_reset)
		chg.refresh |=> snapshot == $past(live);
	endproperty
	a_refresh_loads: assert property (p_refresh_loads)
		else $error("snapshot not refreshed by port access");

	property p_output_excluded;
		@(posedge i_clk) disable iff (i_reset)
		(inputs_only == 4'h0) |-> !chg.mismatch;
	endproperty
	a_output_excluded: assert property (p_output_excluded)
		else $error("output pin caused a change mismatch");
endmodule
`default_nettype wire

// *** pbc_port.sv ***
// Eight-pin bidirectional port with change detection and pull-ups.
// Assumes a plain register port on i_clk and pins that are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module pbc_port (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_reset_is_por,
	// Register port.
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_mem_move_dest,
	output logic [7:0] o_rdata,
	// Pins.
	input wire logic [7:0] i_pin_in,
	output logic [7:0] o_pin_out,
	output logic [7:0] o_pin_oe,
	output logic [7:0] o_pullup_en,
	// Configuration and shared functions.
	input wire logic i_low_pins_analog_default,
	input wire logic i_can_enable,
	input wire logic i_can_transmit_out,
	input wire logic i_lv_program_entry,
	// Signals to neighbouring functions.
	output logic o_ext_irq_zero,
	output logic o_ext_irq_one,
	output logic o_ext_irq_two,
	output logic o_pwm_fault_input,
	output logic o_can_receive_in,
	output logic o_irq_high,
	output logic o_irq_low,
	output logic o_wake
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	logic [7:0] pins_sync;
	logic cfg_sync;
	logic [7:0] port_output_latch;
	logic [7:0] port_direction;
	logic port_change_flag;
	logic port_change_enable;
	logic port_change_priority;
	logic pullup_disable_n;
	logic [3:0] analog_pcfg;
	logic [7:0] analog_mask;
	logic [7:0] pin_read;
	logic [7:0] next_rdata;
	logic port_sel;
	logic port_refresh;

	pbc_change_if chg ();

	// Pins cross into i_clk before anything looks at them.
	pbc_sync #(
		.WIDTH(pbc_pkg::PORT_W)
	) u_pin_sync (
		.i_clk(i_clk),
		.i_reset(1'b0),
		.i_async(i_pin_in),
		.o_sync(pins_sync)
	);

	// The configuration bit is not reset so it is valid during reset;
	// reset must therefore be held for at least three cycles.
	pbc_sync #(
		.WIDTH(1)
	) u_cfg_sync (
		.i_clk(i_clk),
		.i_reset(1'b0),
		.i_async(i_low_pins_analog_default),
		.o_sync(cfg_sync)
	);

	pbc_change_detect u_change (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.chg(chg.detect)
	);

	// Analog selection masks the digital input path of bits 4..0.
	assign analog_mask = {3'h0,
		{5{analog_pcfg < pbc_pkg::PCFG_DIGITAL_MIN}}};
	assign pin_read = pins_sync & ~analog_mask;

	// Any port access counts, except a memory move that targets it.
	assign port_sel = (i_addr == pbc_pkg::ADDR_PIN_VALUE);
	assign port_refresh = port_sel &&
		(i_rd || (i_wr && !i_mem_move_dest));

	assign chg.pin_read = pin_read;
	assign chg.direction = port_direction;
	assign chg.refresh = port_refresh;

	// Output latch; a port write and a latch write are the same store.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			port_output_latch <= pbc_pkg::RST_LATCH;
		end else if (i_wr && (port_sel ||
			i_addr == pbc_pkg::ADDR_OUTPUT_LATCH)) begin
			port_output_latch <= i_wdata;
		end
	end

	// Direction register, all inputs out of reset.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			port_direction <= pbc_pkg::RST_DIRECTION;
		end else if (i_wr && i_addr == pbc_pkg::ADDR_DIRECTION) begin
			port_direction <= i_wdata;
		end
	end

	// Change flag and its enable; a live mismatch beats a software clear.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			port_change_flag <= 1'b0;
			port_change_enable <= 1'b0;
		end else begin
			if (chg.mismatch) begin
				port_change_flag <= 1'b1;
			end else if (i_wr && i_addr == pbc_pkg::ADDR_INT_MAIN) begin
				port_change_flag <= i_wdata[pbc_pkg::BIT_CHANGE_FLAG];
			end
			if (i_wr && i_addr == pbc_pkg::ADDR_INT_MAIN) begin
				port_change_enable <= i_wdata[pbc_pkg::BIT_CHANGE_ENABLE];
			end
		end
	end

	// Shared pull-up control and change priority.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pullup_disable_n <= 1'b1;
			port_change_priority <= 1'b1;
		end else if (i_wr && i_addr == pbc_pkg::ADDR_INT_SECOND) begin
			pullup_disable_n <= i_wdata[pbc_pkg::BIT_PULLUP_DISABLE_N];
			port_change_priority <= i_wdata[pbc_pkg::BIT_CHANGE_PRIORITY];
		end
	end

	// Analog field: only a power-on reset reloads it from the config bit.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			if (i_reset_is_por) begin
				analog_pcfg <= cfg_sync ? pbc_pkg::PCFG_ALL_ANALOG
					: pbc_pkg::PCFG_ALL_DIGITAL;
			end
		end else if (i_wr && i_addr == pbc_pkg::ADDR_ANALOG_CFG) begin
			analog_pcfg <= i_wdata[3:0];
		end
	end

	// Read multiplexer; unused addresses and reserved bits read zero.
	always_comb begin
		next_rdata = 8'h00;
		if (i_addr == pbc_pkg::ADDR_PIN_VALUE) begin
			next_rdata = pin_read;
		end else if (i_addr == pbc_pkg::ADDR_OUTPUT_LATCH) begin
			next_rdata = port_output_latch;
		end else if (i_addr == pbc_pkg::ADDR_DIRECTION) begin
			next_rdata = port_direction;
		end else if (i_addr == pbc_pkg::ADDR_INT_MAIN) begin
			next_rdata[pbc_pkg::BIT_CHANGE_FLAG] = port_change_flag;
			next_rdata[pbc_pkg::BIT_CHANGE_ENABLE] = port_change_enable;
		end else if (i_addr == pbc_pkg::ADDR_INT_SECOND) begin
			next_rdata[pbc_pkg::BIT_PULLUP_DISABLE_N] = pullup_disable_n;
			next_rdata[pbc_pkg::BIT_CHANGE_PRIORITY] = port_change_priority;
		end else if (i_addr == pbc_pkg::ADDR_ANALOG_CFG) begin
			next_rdata[3:0] = analog_pcfg;
		end
	end

	// Read data stands for exactly the cycle after the strobe.
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_rd) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	// Pin drivers; CAN and programming entry override direction.
	always_comb begin
		o_pin_out = port_output_latch;
		o_pin_oe = ~port_direction;
		if (i_can_enable) begin
			o_pin_out[pbc_pkg::BIT_CAN_TX] = i_can_transmit_out;
			o_pin_oe[pbc_pkg::BIT_CAN_TX] = 1'b1;
		end
		if (i_lv_program_entry) begin
			o_pin_oe[pbc_pkg::BIT_LV_PROGRAM] = 1'b0;
		end
	end

	// Pull-ups follow the effective drive, so the CAN override also drops them on bit 2.
	assign o_pullup_en = {8{!pullup_disable_n}} & ~o_pin_oe;

	// Schmitt inputs of neighbouring functions take the raw pin level;
	// CAN receive relies on software leaving bit 3 an input.
	assign o_ext_irq_zero = pins_sync[0];
	assign o_ext_irq_one = pins_sync[1];
	assign o_ext_irq_two = pins_sync[2];
	assign o_pwm_fault_input = pins_sync[0];
	assign o_can_receive_in = pins_sync[pbc_pkg::BIT_CAN_RX];

	// Interrupt request by priority, and wake-up from sleep.
	assign o_irq_high = port_change_flag && port_change_enable &&
		port_change_priority;
	assign o_irq_low = port_change_flag && port_change_enable &&
		!port_change_priority;
	assign o_wake = port_change_flag && port_change_enable;

	sequence s_latch_write;
		i_wr && i_addr == pbc_pkg::ADDR_OUTPUT_LATCH;
	endsequence

	sequence s_latch_read;
		i_rd && i_addr == pbc_pkg::ADDR_OUTPUT_LATCH;
	endsequence

	property p_latch_readback;
		s_latch_write ##1 s_latch_read |=> o_rdata == $past(i_wdata, 2);
	endproperty
	a_latch_readback: assert property (p_latch_readback)
		else $error("latch read does not return stored value");

	property p_direction_drive;
		i_wr && i_addr == pbc_pkg::ADDR_DIRECTION |=>
			(i_can_enable || i_lv_program_entry ||
			o_pin_oe == ~$past(i_wdata));
	endproperty
	a_direction_drive: assert property (p_direction_drive)
		else $error("pin drive does not follow direction");

	property p_pullup_enable;
		i_wr && i_addr == pbc_pkg::ADDR_INT_SECOND &&
			!i_wdata[pbc_pkg::BIT_PULLUP_DISABLE_N] |=>
			o_pullup_en == ~o_pin_oe;
	endproperty
	a_pullup_enable: assert property (p_pullup_enable)
		else $error("pull-ups not enabled by cleared control bit");

	property p_pullup_output_off;
		(o_pullup_en & o_pin_oe) == 8'h00;
	endproperty
	a_pullup_output_off: assert property (p_pullup_output_off)
		else $error("pull-up on a driven pin");

	property p_reset_pullups_off;
		@(posedge i_clk) disable iff (1'b0)
		$past(i_reset) |-> o_pullup_en == 8'h00;
	endproperty
	a_reset_pullups_off: assert property (p_reset_pullups_off)
		else $error("pull-ups on after reset");

	property p_flag_sets;
		chg.mismatch |=> port_change_flag ##1
			(port_change_flag || $past(!chg.mismatch));
	endproperty
	a_flag_sets: assert property (p_flag_sets)
		else $error("mismatch did not hold the change flag");

	property p_analog_reads_low;
		i_rd && port_sel |=> (o_rdata & $past(analog_mask)) == 8'h00;
	endproperty
	a_analog_reads_low: assert property (p_analog_reads_low)
		else $error("analog pin read back high");

	property p_can_takeover;
		i_can_enable |-> o_pin_oe[pbc_pkg::BIT_CAN_TX] &&
			o_pin_out[pbc_pkg::BIT_CAN_TX] == i_can_transmit_out;
	endproperty
	a_can_takeover: assert property (p_can_takeover)
		else $error("CAN transmit did not own bit 2");

	property p_irq_gate;
		(port_change_flag && port_change_enable) ==
			(o_irq_high || o_irq_low) && !(o_irq_high && o_irq_low);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt request not gated by enable");

	// Power-on load is checked only after three held reset cycles, since the
	// configuration synchroniser is not reset and starts out unknown.
	sequence s_por_held;
		(i_reset && i_reset_is_por) ##1 (i_reset && i_reset_is_por) ##1
			(i_reset && i_reset_is_por);
	endsequence

	property p_por_analog_load;
		@(posedge i_clk) disable iff (1'b0)
		s_por_held |=> analog_pcfg ==
			($past(i_low_pins_analog_default, 3) ?
			pbc_pkg::PCFG_ALL_ANALOG : pbc_pkg::PCFG_ALL_DIGITAL);
	endproperty
	a_por_analog_load: assert property (p_por_analog_load)
		else $error("analog field not loaded from config on power-on");

	// A memory move into the port must not end a standing mismatch.
	sequence s_move_into_port;
		(i_wr && port_sel && i_mem_move_dest && chg.mismatch) ##1
			($stable(pin_read) && $stable(port_direction) && !port_refresh);
	endsequence

	property p_move_keeps_mismatch;
		s_move_into_port |-> chg.mismatch;
	endproperty
	a_move_keeps_mismatch: assert property (p_move_keeps_mismatch)
		else $error("memory move into the port ended the mismatch");

	property p_wake_follows;
		chg.mismatch && port_change_enable &&
			!(i_wr && i_addr == pbc_pkg::ADDR_INT_MAIN) |=> o_wake;
	endproperty
	a_wake_follows: assert property (p_wake_follows)
		else $error("enabled change mismatch did not raise wake-up");

	property p_port_read_pins;
		i_rd && port_sel |=> o_rdata == $past(pin_read);
	endproperty
	a_port_read_pins: assert property (p_port_read_pins)
		else $error("port read did not return the pin levels");

	property p_port_write_latch;
		i_wr && port_sel |=> port_output_latch == $past(i_wdata);
	endproperty
	a_port_write_latch: assert property (p_port_write_latch)
		else $error("port write did not reach the output latch");

	property p_lv_program_release;
		i_lv_program_entry |-> !o_pin_oe[pbc_pkg::BIT_LV_PROGRAM];
	endproperty
	a_lv_program_release: assert property (p_lv_program_release)
		else $error("programming entry pin still driven");
endmodule
`default_nettype wire

// *** pbc_pins_model.sv ***
// Pins outside the port: switches with drive enables and weak pull-ups.
// Assumes one clock; a pin that nobody drives and that has no pull-up
// wanders every cycle, so a floating input never passes for a value.
`timescale 1ns/1ps
`default_nettype none
module pbc_pins_model (
	// Clock.
	input wire logic i_clk,
	// Device side.
	input wire logic [7:0] i_pin_out,
	input wire logic [7:0] i_pin_oe,
	input wire logic [7:0] i_pullup_en,
	// Switch side.
	input wire logic [7:0] i_ext_val,
	input wire logic [7:0] i_ext_en,
	output logic [7:0] o_pin
);
	logic [7:0] float_pat = 8'h00;

	// Pattern for undriven pins without a pull-up.
	always @(posedge i_clk) begin
		float_pat <= ~float_pat;
	end

	// Device drive wins, then the switch, then the pull-up.
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			if (i_pin_oe[b])
				o_pin[b] = i_pin_out[b];
			else if (i_ext_en[b])
				o_pin[b] = i_ext_val[b];
			else if (i_pullup_en[b])
				o_pin[b] = 1'b1;
			else
				o_pin[b] = float_pat[b];
		end
	end
endmodule
`default_nettype wire

// *** pbc_port_bench.sv ***
// Self-checking bench for the port: register table, pins and change flag.
// Assumes the pins model stands on the far side of the pin ports.
`timescale 1ns/1ps
`default_nettype none
module pbc_port_bench;
	logic clk, reset, por, adef, wr, rd, mmd, can_en, can_tx, lvp;
	logic [2:0] addr;
	logic [7:0] wdata, ext_val, ext_en;
	logic [7:0] rdata, pin_in, pin_out, oe, pu;
	logic irq0, irq1, irq2, flt, can_receive_in, irqh, irql, wake;
	int err_total = 0;
	int num_checks = 0;
	// Rows: address, write data, expected read-back.
	logic [18:0] rows [8] = '{{3'h1, 8'hA5, 8'hA5}, {3'h2, 8'hF0, 8'hF0},
		{3'h4, 8'hFF, 8'h81}, {3'h6, 8'hFF, 8'h0F}, {3'h5, 8'hFF, 8'h00},
		{3'h7, 8'hFF, 8'h00}, {3'h3, 8'h08, 8'h08}, {3'h3, 8'h00, 8'h00}};

	pbc_port pbc_port_inst (.i_clk(clk), .i_reset(reset),
		.i_reset_is_por(por), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .i_mem_move_dest(mmd), .o_rdata(rdata),
		.i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(oe),
		.o_pullup_en(pu), .i_low_pins_analog_default(adef),
		.i_can_enable(can_en), .i_can_transmit_out(can_tx),
		.i_lv_program_entry(lvp), .o_ext_irq_zero(irq0),
		.o_ext_irq_one(irq1), .o_ext_irq_two(irq2),
		.o_pwm_fault_input(flt), .o_can_receive_in(can_receive_in),
		.o_irq_high(irqh), .o_irq_low(irql), .o_wake(wake));

	pbc_pins_model pbc_pins_model_inst (.i_clk(clk), .i_pin_out(pin_out),
		.i_pin_oe(oe), .i_pullup_en(pu), .i_ext_val(ext_val),
		.i_ext_en(ext_en), .o_pin(pin_in));

	// Clock at 200 MHz.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Verdict and end of run, shared with the watchdog.
	task automatic report_and_stop();
		if (err_total == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write; ends at the falling edge so outputs have settled.
	task automatic bw(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask

	// One-cycle read; data stand only in the cycle after the strobe.
	task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask

	task automatic do_reset(input logic p, input logic d);
		@(posedge clk);
		reset <= 1'b1;
		por <= p;
		adef <= d;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		por <= 1'b0;
	endtask

	// Pins are synchronised over two flops, so allow settling time.
	task automatic pins(input logic [7:0] v);
		@(posedge clk);
		ext_val <= v;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask

	// Cut a hang short well beyond the expected run length.
	initial begin
		#20000;
		err_total++;
		report_and_stop();
	end

	initial begin
		{reset, por, adef} = 3'b111;
		{wr, rd, mmd, can_en, can_tx, lvp} = 6'h00;
		addr = 3'h0;
		wdata = 8'h00;
		ext_val = 8'h03;
		ext_en = 8'hFF;
		do_reset(1'b1, 1'b1);
		for (int i = 0; i < 8; i++) begin
			bw(rows[i][18:16], rows[i][15:8]);
			rdc(rows[i][18:16], rows[i][7:0]);
		end
		// Write then read with no gap; read data stand for one cycle only.
		@(posedge clk);
		addr <= 3'h1;
		wdata <= 8'h3C;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, 8'h3C);
		@(negedge clk);
		chk(rdata, 8'h00);
		bw(3'h1, 8'hA5);
		// Shared pull-up on, lower pins driven as outputs.
		bw(3'h4, 8'h01);
		chk(pu, 8'hF0);
		chk(oe, 8'h0F);
		chk(pin_out, 8'hA5);
		bw(3'h2, 8'hFF);
		@(posedge clk);
		can_en <= 1'b1;
		can_tx <= 1'b1;
		@(negedge clk);
		chk(oe, 8'h04);
		chk(pu, 8'hFB);
		chk({7'h00, pin_out[2]}, 8'h01);
		@(posedge clk);
		can_en <= 1'b0;
		// Direction bit 3 is already an input before receive is used.
		pins(8'h0B);
		chk({3'h0, flt, can_receive_in, irq2, irq1, irq0}, 8'h1B);
		rdc(3'h0, 8'h0B);
		rdc(3'h1, 8'hA5);
		rdc(3'h3, 8'h00);
		// Upper pin change with the change enable set.
		bw(3'h3, 8'h08);
		pins(8'h4B);
		chk({5'h00, irqh, irql, wake}, 8'h05);
		bw(3'h3, 8'h08);
		rdc(3'h3, 8'h09);
		@(posedge clk);
		mmd <= 1'b1;
		bw(3'h0, 8'h00);
		@(posedge clk);
		mmd <= 1'b0;
		bw(3'h3, 8'h08);
		rdc(3'h3, 8'h09);
		// Only to end the mismatch; the port is not polled otherwise.
		rdc(3'h0, 8'h4B);
		bw(3'h3, 8'h08);
		rdc(3'h3, 8'h08);
		chk({7'h00, wake}, 8'h00);
		// Low priority; an output pin never counts as a change.
		bw(3'h4, 8'h00);
		bw(3'h2, 8'h7F);
		bw(3'h1, 8'h80);
		pins(8'h4B);
		rdc(3'h3, 8'h08);
		pins(8'h6B);
		chk({5'h00, irqh, irql, wake}, 8'h03);
		rdc(3'h0, 8'hEB);
		bw(3'h2, 8'h00);
		@(posedge clk);
		lvp <= 1'b1;
		@(negedge clk);
		chk(oe, 8'hDF);
		@(posedge clk);
		lvp <= 1'b0;
		bw(3'h2, 8'hFF);
		chk(pu, 8'hFF);
		// A reset that is not power-on keeps the analog selection.
		do_reset(1'b0, 1'b1);
		@(negedge clk);
		chk(pu, 8'h00);
		rdc(3'h4, 8'h81);
		rdc(3'h6, 8'h0F);
		rdc(3'h2, 8'hFF);
		do_reset(1'b1, 1'b1);
		rdc(3'h6, 8'h00);
		rdc(3'h0, 8'h60);
		// Field codes just below and at the digital threshold.
		bw(3'h6, 8'h04);
		rdc(3'h0, 8'h60);
		bw(3'h6, 8'h05);
		rdc(3'h0, 8'h6B);
		do_reset(1'b1, 1'b0);
		rdc(3'h6, 8'h0F);
		report_and_stop();
	end
endmodule
`default_nettype wire
